//--- src/ptc_timer.sv
// periodic timer top: counter, capture, single pulse and AHB-Lite registers
//
// Notes on behaviour
// - single pulse starts on run bit rise, by software or external clock pin
// - external clock pin rising edge sets run bit by itself in single pulse mode
// - mode field 01 selects capture mode
// - capture source bit picks capture pin or external clock pin
// - output control picks rising, falling or both edges for capture
// - in capture mode counting starts on run bit rising
// - active edge copies counter to compare A and flags interrupt
// - captures never stop or clear the counter; run low stops it
// - match with compare P clears counter to zero, except in single pulse mode
// - compare P match in capture mode also flags interrupt
// - output control 11 blocks capture, counter keeps running
// - clear select, initial level and polarity ignored in capture mode
// - pin edges capture even when the shared pin is an output
// - compare P of zero lets counter run to 3FF before wrap
// - counter is ten bits, maximum 3FF
// - single pulse is mode 10 with output control 11
// - compare A match in single pulse clears run bit and flags interrupt
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module ptc_timer
    import ptc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic capture_in_pin,
    input wire logic ext_timer_clk_pin,
    output logic pulse_out,
    output logic timer_irq
);
    import ptc_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    ptc_edge_if edges ();
    logic run_bit;
    logic [1:0] mode_sel_field;
    logic [1:0] out_ctrl_field;
    logic capture_source_sel;
    logic counter_clear_sel;
    logic initial_out_level;
    logic out_polarity;
    logic [9:0] compare_reg_a;
    logic [9:0] compare_reg_p;
    logic [9:0] count;
    logic flag_a;
    logic flag_p;
    logic run_prev;
    ptc_bus_state_t bus_state;
    logic [7:0] wr_addr;
    logic wr_pend;
    logic [31:0] next_rdata;
    logic is_capture;
    logic is_pulse;
    logic run_rise;
    logic cap_event;
    logic sel_rise;
    logic sel_fall;
    logic match_p;
    logic match_a;
    logic wr_ctrl;
    logic wr_cmpa;
    logic wr_cmpp;
    logic wr_stat;
    logic ext_start;
    logic pulse_end;
    logic addr_take;

    // decode of one register write in the data phase
    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr, input logic pend);
        hit = pend && (a == reg_addr);
    endfunction

    ptc_pin_sync u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .capture_in_pin(capture_in_pin),
        .ext_timer_clk_pin(ext_timer_clk_pin),
        .edges(edges)
    );

    // ************************************************
    // mode and event decode
    // ************************************************
    assign is_capture = (mode_sel_field == MODE_CAPTURE);
    assign is_pulse = (mode_sel_field == MODE_PWM) && (out_ctrl_field == IO_NONE);
    assign run_rise = run_bit & ~run_prev;
    // pin samples taken regardless of its direction elsewhere
    assign sel_rise = capture_source_sel ? edges.clk_rise : edges.cap_rise;
    assign sel_fall = capture_source_sel ? edges.clk_fall : edges.cap_fall;
    // selected edge type; 11 blocks capture, counter unaffected
    always_comb begin
        case (out_ctrl_field)
            IO_RISE: cap_event = sel_rise;
            IO_FALL: cap_event = sel_fall;
            IO_BOTH: cap_event = sel_rise | sel_fall;
            default: cap_event = 1'b0;
        endcase
    end
    // zero in compare P means run to full scale
    assign match_p = (compare_reg_p == CCR_RST) ? (count == CNT_MAX) : (count == compare_reg_p);
    assign match_a = (count == compare_reg_a);
    assign ext_start = is_pulse && !run_bit && edges.clk_rise;
    // stale count from an earlier run must not end the pulse in its first cycle
    assign pulse_end = is_pulse && run_bit && !run_rise && match_a;

    // ************************************************
    // bus slave
    // ************************************************
    assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_ctrl = hit(wr_addr, ADDR_CTRL, wr_pend);
    assign wr_cmpa = hit(wr_addr, ADDR_CMPA, wr_pend);
    assign wr_cmpp = hit(wr_addr, ADDR_CMPP, wr_pend);
    assign wr_stat = hit(wr_addr, ADDR_STAT, wr_pend);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase capture; data phase follows next cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bus_state <= PTC_IDLE;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            bus_state <= addr_take ? PTC_DATA : PTC_IDLE;
            wr_pend <= addr_take && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr[7:0] == ADDR_CTRL) begin
            next_rdata[8:0] = {out_polarity, initial_out_level, counter_clear_sel, capture_source_sel,
                out_ctrl_field, mode_sel_field, run_bit};
        end else if (haddr[7:0] == ADDR_CMPA) begin
            next_rdata[9:0] = compare_reg_a;
        end else if (haddr[7:0] == ADDR_CMPP) begin
            next_rdata[9:0] = compare_reg_p;
        end else if (haddr[7:0] == ADDR_STAT) begin
            next_rdata[1:0] = {flag_p, flag_a};
        end else if (haddr[7:0] == ADDR_CNT) begin
            next_rdata[9:0] = count;
        end
    end

    // read data registered at the address edge, valid through the data phase
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ************************************************
    // control register
    // ************************************************
    // ignored bits are stored but steer nothing in capture mode
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_sel_field <= CTRL_RST[2:1];
            out_ctrl_field <= CTRL_RST[4:3];
            capture_source_sel <= 1'b0;
            counter_clear_sel <= 1'b0;
            initial_out_level <= 1'b0;
            out_polarity <= 1'b0;
        end else if (wr_ctrl) begin
            mode_sel_field <= hwdata[CTRL_MODE_LO +: 2];
            out_ctrl_field <= hwdata[CTRL_IO_LO +: 2];
            capture_source_sel <= hwdata[CTRL_CAPTS];
            counter_clear_sel <= hwdata[CTRL_CCLR];
            initial_out_level <= hwdata[CTRL_OC];
            out_polarity <= hwdata[CTRL_POL];
        end
    end

    // run bit: hardware clear at pulse end beats a software write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_bit <= 1'b0;
        end else if (pulse_end) begin
            run_bit <= 1'b0;
        end else if (ext_start) begin
            run_bit <= 1'b1;
        end else if (wr_ctrl) begin
            run_bit <= hwdata[CTRL_RUN];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= run_bit;
        end
    end

    // ************************************************
    // counter
    // ************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= CCR_RST;
        end else if (run_rise) begin
            count <= CCR_RST;
        end else if (!run_bit) begin
            count <= count;
        end else if (is_pulse) begin
            count <= count + 10'h001;
        end else if (match_p) begin
            count <= CCR_RST;
        end else begin
            count <= count + 10'h001;
        end
    end

    // ************************************************
    // compare registers and capture latch
    // ************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_reg_a <= CCR_RST;
        end else if (is_capture && cap_event) begin
            compare_reg_a <= count;
        end else if (wr_cmpa) begin
            compare_reg_a <= hwdata[9:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            compare_reg_p <= CCR_RST;
        end else if (wr_cmpp) begin
            compare_reg_p <= hwdata[9:0];
        end
    end

    // ************************************************
    // sticky flags, write one to clear, set wins
    // ************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_a <= 1'b0;
            flag_p <= 1'b0;
        end else begin
            if ((is_capture && cap_event) || pulse_end) begin
                flag_a <= 1'b1;
            end else if (wr_stat && hwdata[STAT_AF]) begin
                flag_a <= 1'b0;
            end
            if (is_capture && run_bit && !run_rise && match_p) begin
                flag_p <= 1'b1;
            end else if (wr_stat && hwdata[STAT_PF]) begin
                flag_p <= 1'b0;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    // request stays high while either flag is held
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            timer_irq <= flag_a | flag_p;
            pulse_out <= is_pulse & run_bit;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_mode_cap;
        @(posedge clock) disable iff (!rst_b)
        (is_capture && cap_event) |=> (compare_reg_a == $past(count)) && flag_a;
    endproperty
    a_mode_cap: assert property (p_mode_cap) else $error("capture did not latch count");

    property p_no_cap;
        @(posedge clock) disable iff (!rst_b)
        (out_ctrl_field == IO_NONE && is_capture && !wr_cmpa) |=> $stable(compare_reg_a);
    endproperty
    a_no_cap: assert property (p_no_cap) else $error("capture with edges disabled");

    property p_wrap;
        @(posedge clock) disable iff (!rst_b)
        (run_bit && run_prev && is_capture && match_p) |=> (count == CCR_RST);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_wrap_flag;
        @(posedge clock) disable iff (!rst_b)
        (run_bit && run_prev && is_capture && match_p) |=> flag_p ##1 timer_irq;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag missing");

    property p_full;
        @(posedge clock) disable iff (!rst_b)
        (run_bit && run_prev && is_capture && compare_reg_p == CCR_RST && count != CNT_MAX)
            |=> (count == $past(count) + 10'h001);
    endproperty
    a_full: assert property (p_full) else $error("early wrap with zero period");

    property p_run_count;
        @(posedge clock) disable iff (!rst_b)
        (is_capture && run_bit && run_prev && !match_p) |=> (count == $past(count) + 10'h001);
    endproperty
    a_run_count: assert property (p_run_count) else $error("counter stalled");

    property p_start;
        @(posedge clock) disable iff (!rst_b)
        ext_start && !wr_ctrl |=> run_bit;
    endproperty
    a_start: assert property (p_start) else $error("pin did not start pulse");

    sequence s_pulse_end;
        is_pulse && run_bit && !run_rise && match_a;
    endsequence
    property p_pulse_end;
        @(posedge clock) disable iff (!rst_b)
        s_pulse_end |=> !run_bit && flag_a ##1 !pulse_out;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse did not end");

    property p_sticky;
        @(posedge clock) disable iff (!rst_b)
        (flag_a && !(wr_stat && hwdata[STAT_AF])) |=> flag_a;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule

//--- src/ptc_pkg.sv
// package of constants and types for the periodic timer capture block
package ptc_pkg;
    // ************************************************
    // widths and reset values
    // ************************************************
    localparam int CNT_W = 10;
    localparam logic [9:0] CNT_MAX = 10'h3FF;
    localparam logic [9:0] CCR_RST = 10'h000;
    // ************************************************
    // register byte addresses
    // ************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMPA = 8'h04;
    localparam logic [7:0] ADDR_CMPP = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_CNT = 8'h10;
    // ************************************************
    // control register field positions
    // ************************************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_IO_LO = 3;
    localparam int CTRL_CAPTS = 5;
    localparam int CTRL_CCLR = 6;
    localparam int CTRL_OC = 7;
    localparam int CTRL_POL = 8;
    localparam logic [8:0] CTRL_RST = 9'h000;
    // status register bit positions, write one to clear
    localparam int STAT_AF = 0;
    localparam int STAT_PF = 1;
    // ************************************************
    // encodings
    // ************************************************
    localparam logic [1:0] MODE_CMP = 2'b00;
    localparam logic [1:0] MODE_CAPTURE = 2'b01;
    localparam logic [1:0] MODE_PWM = 2'b10;
    localparam logic [1:0] MODE_TIMER = 2'b11;
    localparam logic [1:0] IO_RISE = 2'b00;
    localparam logic [1:0] IO_FALL = 2'b01;
    localparam logic [1:0] IO_BOTH = 2'b10;
    localparam logic [1:0] IO_NONE = 2'b11;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    // bus slave phases
    typedef enum logic [1:0] {
        PTC_IDLE = 2'b00,
        PTC_DATA = 2'b01
    } ptc_bus_state_t;
endpackage

//--- src/ptc_edge_if.sv
// interface carrying the edges of the synchronised pin samples
`timescale 1ns/100ps
interface ptc_edge_if;
    logic cap_rise;
    logic cap_fall;
    logic clk_rise;
    logic clk_fall;
    modport src (output cap_rise, output cap_fall, output clk_rise, output clk_fall);
    modport dst (input cap_rise, input cap_fall, input clk_rise, input clk_fall);
endinterface

//--- src/ptc_pin_sync.sv
// two-stage synchroniser and edge detector for the two timer input pins
`timescale 1ns/100ps
module ptc_pin_sync (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic capture_in_pin,
    input wire logic ext_timer_clk_pin,
    ptc_edge_if.src edges
);
    logic [1:0] cap_sync;
    logic [1:0] clk_sync;
    logic cap_prev;
    logic clk_prev;

    // first stage is read only by the second stage
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cap_sync <= 2'h0;
            clk_sync <= 2'h0;
        end else begin
            cap_sync <= {cap_sync[0], capture_in_pin};
            clk_sync <= {clk_sync[0], ext_timer_clk_pin};
        end
    end

    // history for edge detection on the settled samples
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cap_prev <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            cap_prev <= cap_sync[1];
            clk_prev <= clk_sync[1];
        end
    end

    // edges from synchronised samples only
    assign edges.cap_rise = cap_sync[1] & ~cap_prev;
    assign edges.cap_fall = ~cap_sync[1] & cap_prev;
    assign edges.clk_rise = clk_sync[1] & ~clk_prev;
    assign edges.clk_fall = ~clk_sync[1] & clk_prev;
endmodule

//--- tb/ptc_pulse_src.sv
// behavioural source of pulses on the two timer input pins
`timescale 1ns/100ps
module ptc_pulse_src (
    input wire logic clock,
    output logic capture_in_pin,
    output logic ext_timer_clk_pin
);
    // ********
    // pin drive
    // ********
    // both pins are driven at all times and idle low, so no released level exists
    initial begin
        capture_in_pin = 1'b0;
        ext_timer_clk_pin = 1'b0;
    end
    // stray pulse on the other pin first, so a wrong source choice lands outside the window
    task automatic pattern(input logic sel_clk, input int d, input int h);
        repeat (5) @(posedge clock);
        if (sel_clk) capture_in_pin <= 1'b1; else ext_timer_clk_pin <= 1'b1;
        repeat (3) @(posedge clock);
        if (sel_clk) capture_in_pin <= 1'b0; else ext_timer_clk_pin <= 1'b0;
        repeat (d - 8) @(posedge clock);
        if (sel_clk) ext_timer_clk_pin <= 1'b1; else capture_in_pin <= 1'b1;
        repeat (h) @(posedge clock);
        if (sel_clk) ext_timer_clk_pin <= 1'b0; else capture_in_pin <= 1'b0;
    endtask
    // single level change on the external clock pin, launched just after an edge
    task automatic clk_level(input logic lvl);
        @(posedge clock);
        ext_timer_clk_pin <= lvl;
    endtask
endmodule

//--- tb/tb_periodic_timer_capture_pulse.sv
// self-checking bench for the periodic timer capture and single pulse block
`timescale 1ns/100ps
module tb_periodic_timer_capture_pulse;
    import ptc_pkg::*;
    typedef struct {
        logic [31:0] lo;
        logic [31:0] hi;
    } ptc_exp_t;
    localparam int LIMIT = 10000;
    localparam logic [7:0] REGS [6] = '{ADDR_CTRL, ADDR_CMPA, ADDR_CMPP, ADDR_STAT, ADDR_CNT, 8'h14};
    logic clock;
    logic rst_b;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic capture_in_pin;
    logic ext_timer_clk_pin;
    logic pulse_out;
    logic timer_irq;
    logic rd_phase;
    logic sig_req;
    logic [1:0] es;
    int err_total;
    int n_tests;
    int cyc;
    ptc_exp_t cur;
    ptc_exp_t exp_rd[$];
    logic [1:0] exp_sig[$];

    ptc_timer uut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .capture_in_pin(capture_in_pin), .ext_timer_clk_pin(ext_timer_clk_pin),
        .pulse_out(pulse_out), .timer_irq(timer_irq));
    ptc_pulse_src src (.clock(clock), .capture_in_pin(capture_in_pin), .ext_timer_clk_pin(ext_timer_clk_pin));

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ********
    // bus master and checks
    // ********
    // one single word transfer; the read note is a window so latency slack stays tolerated
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] lo,
                       input logic [31:0] hi);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rd_phase <= ~wr;
        if (!wr) exp_rd.push_back('{lo, hi});
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h00000000, 32'h00000000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        bus(1'b0, a, 32'h00000000, lo, hi);
    endtask
    // note the expected pulse and interrupt levels, sampled at the following edge
    task automatic chk_sig(input logic [1:0] e);
        @(posedge clock);
        exp_sig.push_back(e);
        sig_req <= 1'b1;
        @(posedge clock);
        sig_req <= 1'b0;
    endtask
    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // watcher: oldest note against each read and pin sample
    always @(posedge clock) begin
        if (rd_phase === 1'b1 && hreadyout === 1'b1 && exp_rd.size() > 0) begin
            cur = exp_rd.pop_front();
            n_tests++;
            if ((hrdata >= cur.lo && hrdata <= cur.hi && hresp === 1'b0) !== 1'b1) begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h", $time, hrdata, cur.lo);
            end
        end
        if (sig_req === 1'b1 && exp_sig.size() > 0) begin
            es = exp_sig.pop_front();
            n_tests++;
            if ({pulse_out, timer_irq} !== es) begin
                err_total++;
                $display("mismatch at %0t: got %h expected %h", $time, {pulse_out, timer_irq}, es);
            end
        end
    end
    // hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, cyc, 0);
            finish_test;
        end
    end
    // ********
    // main sequence
    // ********
    initial begin
        logic [31:0] ctrl;
        logic [31:0] preset;
        int d;
        int h;
        int p;
        int a;
        rst_b = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h00000000;
        rd_phase = 1'b0;
        sig_req = 1'b0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(48276));
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        // reset values, unmapped write ignored
        chk_sig(2'b00);
        wr(8'h14, 32'hFFFFFFFF);
        foreach (REGS[i]) rd(REGS[i], 32'h00000000, 32'h00000000);
        // every source and edge choice; clear, level and polarity bits randomised as they must not matter
        for (int s = 0; s < 2; s++) begin
            for (int io = 0; io < 4; io++) begin
                d = $urandom_range(100, 40);
                h = $urandom_range(60, 20);
                preset = $urandom_range(1023, 512);
                ctrl = ($urandom_range(7, 0) << CTRL_CCLR) | (s << CTRL_CAPTS) | (io << CTRL_IO_LO)
                    | (32'(MODE_CAPTURE) << CTRL_MODE_LO);
                wr(ADDR_CTRL, ctrl);
                wr(ADDR_CMPP, 32'h00000000);
                wr(ADDR_CMPA, preset);
                wr(ADDR_STAT, 32'h00000003);
                wr(ADDR_CTRL, ctrl | 32'h1);
                src.pattern(s[0], d, h);
                repeat (8) @(posedge clock);
                if (io == 0) rd(ADDR_CMPA, d, d + 5);
                else if (io == 3) rd(ADDR_CMPA, preset, preset);
                else rd(ADDR_CMPA, d + h, d + h + 5);
                rd(ADDR_STAT, io != 3, io != 3);
                chk_sig({1'b0, io != 3});
                wr(ADDR_CTRL, ctrl);
            end
        end
        // wrap at compare P while captures are blocked
        p = $urandom_range(20, 5);
        ctrl = (32'(IO_NONE) << CTRL_IO_LO) | (32'(MODE_CAPTURE) << CTRL_MODE_LO);
        wr(ADDR_CMPP, p);
        wr(ADDR_STAT, 32'h00000003);
        wr(ADDR_CTRL, ctrl | 32'h1);
        src.pattern(1'b0, 40, 10);
        rd(ADDR_CNT, 0, p);
        rd(ADDR_STAT, 32'h2, 32'h2);
        wr(ADDR_CTRL, ctrl);
        wr(ADDR_STAT, 32'h00000003);
        rd(ADDR_STAT, 32'h0, 32'h0);
        chk_sig(2'b00);
        rd(ADDR_CMPP, p, p);
        // compare P of zero: full ten-bit run before the wrap
        wr(ADDR_CMPP, 32'h00000000);
        wr(ADDR_CTRL, ctrl | 32'h1);
        repeat (1100) @(posedge clock);
        rd(ADDR_CNT, 72, 84);
        wr(ADDR_CTRL, ctrl);
        // single pulse, first started by the pin, then by software
        a = $urandom_range(80, 30);
        ctrl = (32'(IO_NONE) << CTRL_IO_LO) | (32'(MODE_PWM) << CTRL_MODE_LO);
        wr(ADDR_CMPA, a);
        wr(ADDR_STAT, 32'h00000003);
        wr(ADDR_CTRL, ctrl);
        src.clk_level(1'b1);
        repeat (6) @(posedge clock);
        chk_sig(2'b10);
        rd(ADDR_CTRL, ctrl | 32'h1, ctrl | 32'h1);
        repeat (a + 10) @(posedge clock);
        rd(ADDR_CTRL, ctrl, ctrl);
        rd(ADDR_STAT, 32'h1, 32'h1);
        chk_sig(2'b01);
        src.clk_level(1'b0);
        repeat (6) @(posedge clock);
        wr(ADDR_STAT, 32'h00000003);
        wr(ADDR_CTRL, ctrl | 32'h1);
        repeat (3) @(posedge clock);
        chk_sig(2'b10);
        repeat (a + 10) @(posedge clock);
        chk_sig(2'b01);
        rd(ADDR_CTRL, ctrl, ctrl);
        repeat (2) @(posedge clock);
        finish_test;
    end
endmodule
